// [include/ppfifo_pkg.sv]
// constants and types shared by the parallel-port fifo status and read block
package ppfifo_pkg;
   // register byte addresses
   localparam logic [31:0] CFG_ADDR      = 32'h9040_0000;
   localparam logic [31:0] STAT_ADDR     = 32'h9040_0008;
   localparam logic [31:0] CMD_WIN_ADDR  = 32'h9040_000C;
   localparam logic [31:0] DAT_WIN_ADDR  = 32'h9040_0010;
   localparam logic [31:0] IRQ_STAT_ADDR = 32'h9040_0030;
   localparam logic [31:0] IRQ_MASK_ADDR = 32'h9040_0034;

   // status register field positions
   localparam int CMD_VB_LSB    = 14;
   localparam int CMD_EMPTY_BIT = 13;
   localparam int CMD_NE_BIT    = 12;
   localparam int CMD_RDY_BIT   = 11;
   localparam int DAT_VB_LSB    = 6;
   localparam int DAT_EMPTY_BIT = 5;
   localparam int DAT_NE_BIT    = 4;
   localparam int DAT_RDY_BIT   = 3;
   localparam int REV_FULL_BIT  = 2;
   localparam int REV_NF_BIT    = 1;
   localparam int REV_RDY_BIT   = 0;

   // configuration register fields
   localparam int          CFG_CMD_DMA_BIT = 3;
   localparam int          CFG_DAT_DMA_BIT = 1;
   localparam int          CFG_REV_DMA_BIT = 0;
   localparam int          LVL_W           = 4;
   localparam int          CFG_CMD_LVL_LSB = 8;
   localparam int          CFG_DAT_LVL_LSB = 12;
   localparam int          CFG_REV_LVL_LSB = 16;
   localparam logic [31:0] CFG_RESET       = 32'h0001_1100;
   localparam logic [31:0] CFG_WMASK       = 32'h000F_FF0B;

   // interrupt event positions
   localparam int        EV_W          = 5;
   localparam int        EV_CMD_RDY    = 0;
   localparam int        EV_DAT_RDY    = 1;
   localparam int        EV_REV_RDY    = 2;
   localparam int        EV_CMD_UFLOW  = 3;
   localparam int        EV_DAT_UFLOW  = 4;
   localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

   // channel indices
   localparam int CH_CMD = 0;
   localparam int CH_DAT = 1;

   // one forward fifo entry: byte count code (00 = four) and data
   typedef struct packed {
      logic [1:0]  nbytes_code;
      logic [31:0] data;
   } entry_t;
endpackage : ppfifo_pkg

// [core/ppfifo_status_read.sv]
// fifo status register and forward fifo read windows behind an apb slave
`timescale 1ns/1ps
// What this block does
// - command entry valid-byte code at bits 15:14
// - data entry valid-byte code at bits 7:6
// - byte codes, almost-empty meaningless when empty
// - command empty flag bit 13, resets 1
// - command one-entry-left flag bit 12, resets 1
// - command ready when threshold met, bit 11
// - data empty flag bit 5, resets 1
// - data one-entry-left flag bit 4, resets 0
// - data ready when threshold met, bit 3
// - reverse full flag bit 2
// - reverse room-for-one flag bit 1
// - reverse ready when free space meets threshold
// - command window read pops up to four bytes
// - data window read pops up to four bytes
// - per-path select cpu (0) or dma (1)
module ppfifo_status_read
   import ppfifo_pkg::*;
#(
   parameter int DEPTH     = 8,
   parameter int REV_DEPTH = 8,
   localparam int RW       = $clog2(REV_DEPTH + 1)
) (
   input  wire logic          CLK,
   input  wire logic          RST,
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [31:0]   PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic      [31:0]   PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   input  wire logic          CMD_PUSH,
   input  wire entry_t        CMD_ENTRY,
   output logic               CMD_SPACE,
   input  wire logic          DAT_PUSH,
   input  wire entry_t        DAT_ENTRY,
   output logic               DAT_SPACE,
   input  wire logic [RW-1:0] REV_LEVEL,
   input  wire logic [1:0]    DMA_POP,
   output logic      [2:0]    DMA_REQ,
   output logic               IRQ
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int AW = $clog2(DEPTH);

   logic [31:0]     cfg_q;
   logic [EV_W-1:0] irq_stat_q;
   logic [EV_W-1:0] irq_stat_d;
   logic [EV_W-1:0] irq_mask_q;
   logic [EV_W-1:0] events;
   logic [2:0]      rdy_prev_q;
   logic [1:0]      space_q;
   logic [CW-1:0]   cnt_q [2];
   entry_t          head [2];
   logic [1:0]      push;
   logic [1:0]      pop;
   logic [1:0]      empty;
   logic [1:0]      one_left;
   logic [1:0]      rdy;
   logic [1:0]      uflow;
   logic [1:0]      rd_win;
   logic [1:0]      dma_sel;
   logic [1:0]      vb_code [2];
   logic [31:0]     status;
   logic [31:0]     rd_data;

   // apb decode
   wire access   = PSEL & PENABLE;
   wire answer   = access & ~PREADY;
   wire done     = access & PREADY;
   wire hit_cfg  = (PADDR == CFG_ADDR);
   wire hit_stat = (PADDR == STAT_ADDR);
   wire hit_cwin = (PADDR == CMD_WIN_ADDR);
   wire hit_dwin = (PADDR == DAT_WIN_ADDR);
   wire hit_ist  = (PADDR == IRQ_STAT_ADDR);
   wire hit_imsk = (PADDR == IRQ_MASK_ADDR);
   wire mapped   = hit_cfg | hit_stat | hit_cwin | hit_dwin | hit_ist | hit_imsk;
   wire wr_cfg   = done & PWRITE & hit_cfg;
   wire wr_mask  = done & PWRITE & hit_imsk;
   wire rd_ist   = done & ~PWRITE & hit_ist;

   // path mode select
   assign dma_sel[CH_CMD] = cfg_q[CFG_CMD_DMA_BIT];
   assign dma_sel[CH_DAT] = cfg_q[CFG_DAT_DMA_BIT];
   wire   rev_dma         = cfg_q[CFG_REV_DMA_BIT];

   // window reads pop only in cpu mode
   assign rd_win[CH_CMD] = done & ~PWRITE & hit_cwin & ~dma_sel[CH_CMD];
   assign rd_win[CH_DAT] = done & ~PWRITE & hit_dwin & ~dma_sel[CH_DAT];
   assign push[CH_CMD]   = CMD_PUSH;
   assign push[CH_DAT]   = DAT_PUSH;

   wire [LVL_W-1:0] lvl [2];
   assign lvl[CH_CMD] = cfg_q[CFG_CMD_LVL_LSB +: LVL_W];
   assign lvl[CH_DAT] = cfg_q[CFG_DAT_LVL_LSB +: LVL_W];
   wire [LVL_W-1:0] rev_lvl = cfg_q[CFG_REV_LVL_LSB +: LVL_W];

   // forward fifos
   for (genvar c = 0; c < 2; c++) begin : g_fwd
      entry_t        mem [DEPTH];
      logic [AW-1:0] wp_q;
      logic [AW-1:0] rp_q;
      logic [CW-1:0] cnt_d;
      logic [CW-1:0] cnt_r_q;
      logic          space_r_q;

      assign cnt_q[c]   = cnt_r_q;
      assign space_q[c] = space_r_q;

      wire push_ok = push[c] & (cnt_q[c] != CW'(DEPTH));
      wire pop_ok  = pop[c] & ~empty[c];

      assign pop[c]      = dma_sel[c] ? DMA_POP[c] : rd_win[c];
      assign head[c]     = mem[rp_q];
      assign empty[c]    = (cnt_q[c] == '0);
      assign one_left[c] = (cnt_q[c] == CW'(1));
      assign rdy[c]      = ~empty[c] && (int'(cnt_q[c]) >= int'(lvl[c]));
      assign uflow[c]    = pop[c] & empty[c];
      // code forced to four-byte value while empty
      assign vb_code[c]  = empty[c] ? 2'h0 : head[c].nbytes_code;
      assign cnt_d       = cnt_q[c] + CW'(push_ok) - CW'(pop_ok);

      always_ff @(posedge CLK) begin
         if (push_ok) begin
            mem[wp_q] <= (c == CH_CMD) ? CMD_ENTRY : DAT_ENTRY;
         end
      end

      always_ff @(posedge CLK or posedge RST) begin
         if (RST) begin
            wp_q      <= '0;
            rp_q      <= '0;
            cnt_r_q   <= '0;
            space_r_q <= 1'b1;
         end else begin
            wp_q      <= push_ok ? AW'(wp_q + AW'(1)) : wp_q;
            rp_q      <= pop_ok ? AW'(rp_q + AW'(1)) : rp_q;
            cnt_r_q   <= cnt_d;
            space_r_q <= (cnt_d != CW'(DEPTH));
         end
      end

      pop_count_a: assert property (@(posedge CLK) disable iff (RST)
         pop[c] && !empty[c] && !push[c] |=> cnt_q[c] == $past(cnt_q[c]) - CW'(1))
         else $error("pop did not remove one entry");
   end

   // reverse fifo occupancy flags
   wire [RW-1:0] rev_free = RW'(REV_DEPTH) - REV_LEVEL;
   wire rev_full = (REV_LEVEL >= RW'(REV_DEPTH));
   wire rev_nf   = (rev_free == RW'(1));
   wire rev_rdy  = ~rev_full && (int'(rev_free) >= int'(rev_lvl));

   // status word
   always_comb begin
      status                              = '0;
      status[CMD_VB_LSB +: 2]             = vb_code[CH_CMD];
      status[CMD_EMPTY_BIT]               = empty[CH_CMD];
      status[CMD_NE_BIT]                  = empty[CH_CMD] | one_left[CH_CMD];
      status[CMD_RDY_BIT]                 = rdy[CH_CMD];
      status[DAT_VB_LSB +: 2]             = vb_code[CH_DAT];
      status[DAT_EMPTY_BIT]               = empty[CH_DAT];
      status[DAT_NE_BIT]                  = one_left[CH_DAT];
      status[DAT_RDY_BIT]                 = rdy[CH_DAT];
      status[REV_FULL_BIT]                = rev_full;
      status[REV_NF_BIT]                  = rev_nf;
      status[REV_RDY_BIT]                 = rev_rdy;
   end

   // read data selection
   assign rd_data = hit_cfg  ? cfg_q :
                    hit_stat ? status :
                    (hit_cwin && !dma_sel[CH_CMD] && !empty[CH_CMD]) ? head[CH_CMD].data :
                    (hit_dwin && !dma_sel[CH_DAT] && !empty[CH_DAT]) ? head[CH_DAT].data :
                    hit_ist  ? {{(32-EV_W){1'b0}}, irq_stat_q} :
                    hit_imsk ? {{(32-EV_W){1'b0}}, irq_mask_q} : 32'h0000_0000;

   // interrupt events, set wins over read clear
   assign events[EV_CMD_RDY]   = rdy[CH_CMD] & ~rdy_prev_q[0];
   assign events[EV_DAT_RDY]   = rdy[CH_DAT] & ~rdy_prev_q[1];
   assign events[EV_REV_RDY]   = rev_rdy & ~rdy_prev_q[2];
   assign events[EV_CMD_UFLOW] = uflow[CH_CMD];
   assign events[EV_DAT_UFLOW] = uflow[CH_DAT];
   assign irq_stat_d           = (rd_ist ? '0 : irq_stat_q) | events;

   // apb answer, one wait state
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= '0;
      end else begin
         PREADY  <= answer;
         PSLVERR <= answer & ~mapped;
         PRDATA  <= (answer && !PWRITE) ? rd_data : '0;
      end
   end

   // configuration and interrupt registers
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg_q      <= CFG_RESET;
         irq_mask_q <= IRQ_MASK_RESET;
         irq_stat_q <= '0;
         rdy_prev_q <= '0;
      end else begin
         cfg_q      <= wr_cfg ? (PWDATA & CFG_WMASK) : cfg_q;
         irq_mask_q <= wr_mask ? PWDATA[EV_W-1:0] : irq_mask_q;
         irq_stat_q <= irq_stat_d;
         rdy_prev_q <= {rev_rdy, rdy[CH_DAT], rdy[CH_CMD]};
      end
   end

   // outward flags
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         IRQ     <= 1'b0;
         DMA_REQ <= '0;
      end else begin
         IRQ     <= |(irq_stat_d & irq_mask_q);
         DMA_REQ <= {rev_dma & rev_rdy, dma_sel[CH_DAT] & rdy[CH_DAT],
                     dma_sel[CH_CMD] & rdy[CH_CMD]};
      end
   end

   assign CMD_SPACE = space_q[CH_CMD];
   assign DAT_SPACE = space_q[CH_DAT];

   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   apb_wait_a: assert property (answer |=> PREADY ##1 !PREADY)
      else $error("apb answer not one wait state");

   cmd_empty_a: assert property (
      one_left[CH_CMD] && pop[CH_CMD] && !push[CH_CMD] |=> status[CMD_EMPTY_BIT])
      else $error("command empty flag missed last pop");

   cmd_nearly_a: assert property (
      cnt_q[CH_CMD] == CW'(2) && pop[CH_CMD] && !push[CH_CMD]
      |=> status[CMD_NE_BIT] && !status[CMD_EMPTY_BIT])
      else $error("command almost-empty flag wrong");

   dat_nearly_a: assert property ($rose(status[DAT_NE_BIT]) |-> !status[DAT_EMPTY_BIT])
      else $error("data almost-empty set while empty");

   cmd_code_a: assert property (
      empty[CH_CMD] && CMD_PUSH && !pop[CH_CMD]
      |=> status[CMD_VB_LSB +: 2] == $past(CMD_ENTRY.nbytes_code))
      else $error("command byte code not shown");

   dat_window_a: assert property (
      answer && hit_dwin && !PWRITE && !dma_sel[CH_DAT] && !empty[CH_DAT]
      |=> PREADY && PRDATA == $past(head[CH_DAT].data))
      else $error("data window returned wrong word");

   reserved_a: assert property (
      PREADY && hit_stat |-> PRDATA[31:16] == 16'h0000 && PRDATA[10:8] == 3'h0)
      else $error("reserved status bits not zero");

   rev_flags_a: assert property (
      PREADY && hit_stat && REV_LEVEL == RW'(REV_DEPTH) && $stable(REV_LEVEL)
      |-> PRDATA[REV_FULL_BIT] && !PRDATA[REV_RDY_BIT])
      else $error("reverse full flags wrong");

   dma_mode_a: assert property (
      done && hit_cwin && dma_sel[CH_CMD] && !DMA_POP[CH_CMD] && !CMD_PUSH
      |=> $stable(cnt_q[CH_CMD]))
      else $error("window read popped in dma mode");

   dat_dma_a: assert property (
      done && hit_dwin && dma_sel[CH_DAT] && !DMA_POP[CH_DAT] && !DAT_PUSH
      |=> $stable(cnt_q[CH_DAT]))
      else $error("data window read popped in dma mode");

   dat_empty_a: assert property (
      one_left[CH_DAT] && pop[CH_DAT] && !push[CH_DAT] |=> status[DAT_EMPTY_BIT])
      else $error("data empty flag missed last pop");

   dat_code_a: assert property (
      empty[CH_DAT] && DAT_PUSH && !pop[CH_DAT]
      |=> status[DAT_VB_LSB +: 2] == $past(DAT_ENTRY.nbytes_code))
      else $error("data byte code not shown");

   cmd_window_a: assert property (
      answer && hit_cwin && !PWRITE && !dma_sel[CH_CMD] && !empty[CH_CMD]
      |=> PREADY && PRDATA == $past(head[CH_CMD].data))
      else $error("command window returned wrong word");

   empty_window_a: assert property (
      answer && hit_cwin && !PWRITE && empty[CH_CMD] |=> PRDATA == 32'h0000_0000)
      else $error("empty command window not zero");

   cmd_ready_a: assert property (
      status[CMD_RDY_BIT] |-> !empty[CH_CMD])
      else $error("command ready while empty");

   dat_ready_a: assert property (
      status[DAT_RDY_BIT] |-> !empty[CH_DAT])
      else $error("data ready while empty");

   cmd_one_a: assert property (
      status[CMD_NE_BIT] |-> cnt_q[CH_CMD] <= CW'(1))
      else $error("command almost-empty with many entries");

   dat_one_a: assert property (
      status[DAT_NE_BIT] |-> cnt_q[CH_DAT] == CW'(1))
      else $error("data almost-empty with wrong count");

   rev_nearly_a: assert property (
      REV_LEVEL == RW'(REV_DEPTH - 1) |-> status[REV_NF_BIT] && !status[REV_FULL_BIT])
      else $error("reverse almost-full flag wrong");

   rev_room_a: assert property (
      REV_LEVEL < RW'(REV_DEPTH) |-> !status[REV_FULL_BIT])
      else $error("reverse full with room left");

   dma_req_a: assert property (
      !dma_sel[CH_CMD] |=> !DMA_REQ[CH_CMD])
      else $error("dma request in cpu mode");

   unmapped_a: assert property (
      PREADY && !mapped |-> PSLVERR && PRDATA == 32'h0000_0000)
      else $error("unmapped access not refused");

   cmd_uflow_a: assert property (
      done && hit_cwin && !PWRITE && !dma_sel[CH_CMD] && empty[CH_CMD]
      |=> irq_stat_q[EV_CMD_UFLOW])
      else $error("command underflow not flagged");
endmodule : ppfifo_status_read

// [tb/pp_host_model.sv]
// host-side model: pushes forward entries, sets reverse level
`timescale 1ns/1ps
module pp_host_model
   import ppfifo_pkg::*;
(
   input  wire logic       CLK,
   output logic            CMD_PUSH,
   output entry_t          CMD_ENTRY,
   output logic            DAT_PUSH,
   output entry_t          DAT_ENTRY,
   output logic      [3:0] REV_LEVEL,
   output logic      [1:0] DMA_POP
);
   initial begin
      CMD_PUSH = 1'b0;
      DAT_PUSH = 1'b0;
      CMD_ENTRY = '0;
      DAT_ENTRY = '1;
      REV_LEVEL = 4'h0;
      DMA_POP = 2'h0; // cpu mode, no dma pop until pop_dma drives one
   end
   task automatic push(input int ch, input entry_t e);
      @(posedge CLK);
      if (ch == CH_CMD) begin
         CMD_PUSH <= 1'b1;
         CMD_ENTRY <= e;
      end else begin
         DAT_PUSH <= 1'b1;
         DAT_ENTRY <= e;
      end
      @(posedge CLK);
      CMD_PUSH <= 1'b0;
      DAT_PUSH <= 1'b0;
      CMD_ENTRY <= ~CMD_ENTRY;
      DAT_ENTRY <= ~DAT_ENTRY;
   endtask : push
   task automatic set_rev(input logic [3:0] v);
      @(posedge CLK);
      REV_LEVEL <= v;
   endtask : set_rev
   task automatic pop_dma(input int ch);
      @(posedge CLK);
      DMA_POP[ch] <= 1'b1;
      @(posedge CLK);
      DMA_POP <= 2'h0;
   endtask : pop_dma
endmodule : pp_host_model

// [tb/parallel_port_fifo_status_read_test.sv]
// self-checking bench for the fifo status and read windows
`timescale 1ns/1ps
module parallel_port_fifo_status_read_test;
   import ppfifo_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic        cmd_push, dat_push;
   logic [31:0] paddr, pwdata, prdata, seed;
   entry_t      cmd_entry, dat_entry;
   entry_t      ent[4];
   logic [3:0]  rev_level;
   logic [1:0]  dma_pop;
   logic [2:0]  dma_req;
   logic [33:0] q[$];
   logic [33:0] x;
   int          err_count, n_tests;
   int          cyc = 0;
   ppfifo_status_read dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CMD_PUSH(cmd_push), .CMD_ENTRY(cmd_entry), .CMD_SPACE(),
      .DAT_PUSH(dat_push), .DAT_ENTRY(dat_entry), .DAT_SPACE(), .REV_LEVEL(rev_level),
      .DMA_POP(dma_pop), .DMA_REQ(dma_req), .IRQ(irq));
   pp_host_model host_u (.CLK(clk), .CMD_PUSH(cmd_push), .CMD_ENTRY(cmd_entry),
      .DAT_PUSH(dat_push), .DAT_ENTRY(dat_entry), .REV_LEVEL(rev_level), .DMA_POP(dma_pop));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   function automatic logic [31:0] st(input int ch, input int n, input logic [1:0] c);
      logic [31:0] v;
      int          o;
      v = 32'h0000_3021;
      o = (ch == CH_CMD) ? 0 : 8;
      if (n > 0) begin
         v[CMD_EMPTY_BIT - o] = 1'b0;
         v[CMD_NE_BIT - o] = (n == 1);
         v[CMD_RDY_BIT - o] = 1'b1;
         v[CMD_VB_LSB - o +: 2] = c;
      end
      return v;
   endfunction : st
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         err_count++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   // one apb transfer; ex = {check data, error expected, data}
   task automatic xfer(input logic w, input logic [31:0] a, d, input logic [33:0] ex);
      q.push_back(ex);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [31:0] a, input logic [31:0] v);
      xfer(1'b0, a, 32'h0, {2'b10, v});
   endtask : rd
   always @(negedge clk) begin
      if (pready === 1'b1 && q.size() > 0) begin
         x = q.pop_front();
         check(pslverr, x[32]);
         if (x[33]) check(prdata, x[31:0]);
      end
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      seed = 32'hCF04;
      err_count = 0;
      n_tests = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(CFG_ADDR, CFG_RESET);
      rd(STAT_ADDR, 32'h0000_3021);
      xfer(1'b1, STAT_ADDR, 32'hFFFF_FFFF, 34'h0);
      rd(STAT_ADDR, 32'h0000_3021);
      xfer(1'b0, 32'h9040_0004, 32'h0, 34'h1_0000_0000);
      xfer(1'b0, IRQ_STAT_ADDR, 32'h0, 34'h0);
      $display("reset and register test done");
      for (int ch = 0; ch < 2; ch++) begin
         xfer(1'b1, IRQ_MASK_ADDR, 32'h1 << ch, 34'h0);
         @(negedge clk);
         check(irq, 1'b0);
         for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            ent[k] = {2'(k), seed};
            host_u.push(ch, ent[k]);
         end
         for (int k = 0; k < 4; k++) begin
            rd(STAT_ADDR, st(ch, 4 - k, ent[k].nbytes_code));
            if (k == 0) begin
               @(negedge clk);
               check(irq, 1'b1);
               rd(IRQ_STAT_ADDR, 32'h1 << ch);
            end
            rd(ch ? DAT_WIN_ADDR : CMD_WIN_ADDR, ent[k].data);
         end
         @(negedge clk);
         check(irq, 1'b0);
         rd(STAT_ADDR, 32'h0000_3021);
         rd(ch ? DAT_WIN_ADDR : CMD_WIN_ADDR, 32'h0);
         rd(IRQ_STAT_ADDR, 32'h8 << ch);
         $display("fifo channel %0d test done", ch);
      end
      host_u.set_rev(4'd8);
      rd(STAT_ADDR, 32'h0000_3024);
      host_u.set_rev(4'd7);
      rd(STAT_ADDR, 32'h0000_3023);
      xfer(1'b1, CFG_ADDR, 32'h0002_1101, 34'h0);
      rd(STAT_ADDR, 32'h0000_3022);
      host_u.set_rev(4'd0);
      rd(STAT_ADDR, 32'h0000_3021);
      @(negedge clk);
      check(dma_req, 3'b100);
      $display("reverse flags test done");
      xfer(1'b1, CFG_ADDR, 32'h0001_1108, 34'h0);
      seed = lfsr(seed);
      host_u.push(CH_CMD, {2'h1, seed});
      rd(CMD_WIN_ADDR, 32'h0);
      @(negedge clk);
      check(dma_req, 3'b001);
      host_u.pop_dma(CH_CMD);
      rd(STAT_ADDR, 32'h0000_3021);
      $display("dma mode test done");
      complete_run();
   end
endmodule : parallel_port_fifo_status_read_test
